// file: fcfs_pkg.sv
// constants, types and timing for the calibration stream host
// assumes a 100 MHz clock and an open-drain two-wire bus with external pull-ups
package fcfs_pkg;
   localparam int CLK_KHZ = 100_000;
   localparam int I2C_KHZ = 100;
   localparam int QTR_CYC = CLK_KHZ / (I2C_KHZ * 4);
   localparam int MS_UNIT = 1;
   localparam int MS_CYC_DEF = CLK_KHZ * MS_UNIT;
   localparam int POLL_GAP_MS = 500;
   localparam int EXIT_WAIT_MS = 250;
   localparam int MAX_BYTES = 96;
   localparam int MAX_RETRY = 3;
   localparam logic [7:0] CH_W = 8'h57;
   localparam logic [7:0] CH_C = 8'h43;
   localparam logic [7:0] CH_X = 8'h58;
   localparam logic [7:0] CH_COLON = 8'h3a;
   localparam logic [7:0] CH_SEMI = 8'h3b;
   localparam logic [7:0] CH_NL = 8'h0a;
   localparam logic [7:0] CH_CR = 8'h0d;
   localparam logic [7:0] CH_SP = 8'h20;
   localparam logic [7:0] CH_TAB = 8'h09;
   localparam logic [7:0] CH_EOT = 8'h04;
   localparam logic [7:0] CH_0 = 8'h30;
   localparam logic [7:0] CH_9 = 8'h39;
   localparam logic [7:0] CH_UA = 8'h41;
   localparam logic [7:0] CH_UF = 8'h46;
   localparam logic [7:0] CH_LA = 8'h61;
   localparam logic [7:0] CH_LF = 8'h66;
   localparam logic [3:0] HEX_ADJ = 4'h9;
   localparam logic [15:0] DEC_BASE = 16'h000a;
   localparam logic [2:0] SEQ_AW = 3'h0;
   localparam logic [2:0] SEQ_REG = 3'h1;
   localparam logic [2:0] SEQ_DW = 3'h2;
   localparam logic [2:0] SEQ_AR = 3'h3;
   localparam logic [2:0] SEQ_DR = 3'h4;
   typedef enum logic [1:0] {CMD_NONE, CMD_W, CMD_C, CMD_X} fcfs_cmd_type;
   typedef enum logic [2:0] {STEP_NONE, STEP_OFFSET, STEP_LEAK, STEP_CURR, STEP_VOLT, STEP_TEMP,
                             STEP_STORE} fcfs_step_type;
   typedef struct packed {
      logic scl_o;
      logic scl_oe_n;
      logic sda_o;
      logic sda_oe_n;
   } fcfs_pins_type;
   typedef struct packed {
      fcfs_cmd_type cmd;
      logic [6:0] addr7;
      logic [7:0] reg_a;
      logic [6:0] cnt;
      logic [15:0] ms;
   } fcfs_row_type;
endpackage

// file: fcfs_stream_host.sv
// text-stream interpreter and two-wire master for gauge calibration and flash streams
// assumes chars arrive on a valid/ready port; control inputs come from logic on clk
`timescale 1ns/1ps
module fcfs_stream_host #(
   parameter int MS_CYC = fcfs_pkg::MS_CYC_DEF
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [7:0] char_data,
   input wire logic char_valid,
   output logic char_ready,
   input wire logic start,
   input wire fcfs_pkg::fcfs_step_type step_sel,
   input wire logic gauge_open,
   input wire logic slow_poll,
   input wire logic exit_wait,
   output logic busy,
   output logic done,
   output logic error,
   output logic restart,
   output logic [3:0] retry_cnt,
   output logic [6:0] cal_done,
   input wire logic scl_i,
   output logic scl_o,
   output logic scl_oe_n,
   input wire logic sda_i,
   output logic sda_o,
   output logic sda_oe_n
);
   import fcfs_pkg::*;

   typedef enum logic [3:0] {ST_IDLE, ST_PARSE, ST_GAP, ST_START, ST_BYTE, ST_STOP, ST_WAIT, ST_FLUSH,
                             ST_EXIT} fcfs_state_type;

   // ***************************************************************
   // pin synchronisers
   // ***************************************************************
   logic scl_m_r, scl_s_r, sda_m_r, sda_s_r;
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         scl_m_r <= 1'h1;
         scl_s_r <= 1'h1;
         sda_m_r <= 1'h1;
         sda_s_r <= 1'h1;
      end else begin
         scl_m_r <= scl_i;
         scl_s_r <= scl_m_r;
         sda_m_r <= sda_i;
         sda_s_r <= sda_m_r;
      end
   end

   // ***************************************************************
   // interpreter state
   // ***************************************************************
   fcfs_state_type st_r, st_nxt;
   fcfs_row_type row_r, row_nxt;
   fcfs_pins_type pins_r, pins_nxt;
   fcfs_step_type step_r, step_nxt;
   logic [1:0] line_r, line_nxt, ph_r, ph_nxt;
   logic intok_r, intok_nxt, fail_r, fail_nxt;
   logic ready_r, ready_nxt, busy_r, busy_nxt, done_r, done_nxt;
   logic error_r, error_nxt, restart_r, restart_nxt;
   logic [15:0] acc_r, acc_nxt, ms_left_r, ms_left_nxt, gap_r, gap_nxt;
   logic [6:0] tok_r, tok_nxt, bi_r, bi_nxt, cal_r, cal_nxt;
   logic [16:0] tm_r, tm_nxt, gsub_r, gsub_nxt;
   logic [3:0] bit_r, bit_nxt, retry_r, retry_nxt, nib;
   logic [7:0] sh_r, sh_nxt, ch;
   logic [2:0] seq_r, seq_nxt;
   logic [7:0] mem_r [MAX_BYTES];
   logic mem_we;
   logic [6:0] mem_wa;
   logic [7:0] mem_wd;
   logic is_dec, is_hex, is_ws, tick, last, ok_step, fault, decide, finish, scl_low, sda_low;

   always_comb begin
      ch = char_data;
      is_dec = (ch >= CH_0) && (ch <= CH_9);
      is_hex = is_dec || ((ch >= CH_UA) && (ch <= CH_UF)) || ((ch >= CH_LA) && (ch <= CH_LF));
      is_ws = (ch == CH_SP) || (ch == CH_TAB) || (ch == CH_CR);
      nib = is_dec ? ch[3:0] : 4'(ch[3:0] + HEX_ADJ);
      tick = (tm_r == 17'(QTR_CYC - 1)) && (!pins_r.scl_oe_n || scl_s_r);
      last = (bi_r == 7'(row_r.cnt - 7'h1));
      fault = 1'h0;
      decide = 1'h0;
      finish = 1'h0;
      ok_step = 1'h0;
      st_nxt = st_r;
      row_nxt = row_r;
      step_nxt = step_r;
      line_nxt = line_r;
      ph_nxt = ph_r;
      intok_nxt = intok_r;
      fail_nxt = fail_r;
      busy_nxt = busy_r;
      done_nxt = done_r;
      error_nxt = error_r;
      restart_nxt = 1'h0;
      acc_nxt = acc_r;
      ms_left_nxt = ms_left_r;
      tok_nxt = tok_r;
      bi_nxt = bi_r;
      cal_nxt = cal_r;
      tm_nxt = tm_r;
      bit_nxt = bit_r;
      retry_nxt = retry_r;
      sh_nxt = sh_r;
      seq_nxt = seq_r;
      mem_we = 1'h0;
      mem_wa = row_r.cnt;
      mem_wd = acc_r[7:0];
      // milliseconds since the last gauge read, saturating
      if (gsub_r == 17'(MS_CYC - 1)) begin
         gsub_nxt = 17'h0;
         gap_nxt = (gap_r == 16'hffff) ? gap_r : 16'(gap_r + 16'h1);
      end else begin
         gsub_nxt = 17'(gsub_r + 17'h1);
         gap_nxt = gap_r;
      end
      if (st_r == ST_START || st_r == ST_BYTE || st_r == ST_STOP) begin
         if (tick) begin
            tm_nxt = 17'h0;
            ph_nxt = 2'(ph_r + 2'h1);
         end else if (tm_r != 17'(QTR_CYC - 1)) begin
            tm_nxt = 17'(tm_r + 17'h1);
         end
      end
      case (step_sel)
         STEP_NONE, STEP_OFFSET, STEP_LEAK: ok_step = 1'h1;
         STEP_CURR: ok_step = cal_r[STEP_OFFSET];
         STEP_VOLT: ok_step = cal_r[STEP_CURR];
         STEP_TEMP: ok_step = cal_r[STEP_VOLT];
         STEP_STORE: ok_step = cal_r[STEP_TEMP];
         default: ok_step = 1'h0;
      endcase
      case (st_r)
         ST_IDLE: begin
            if (start) begin
               done_nxt = 1'h0;
               if (gauge_open && ok_step) begin
                  busy_nxt = 1'h1;
                  error_nxt = 1'h0;
                  retry_nxt = 4'h0;
                  step_nxt = step_sel;
                  line_nxt = 2'h0;
                  intok_nxt = 1'h0;
                  fail_nxt = 1'h0;
                  st_nxt = ST_PARSE;
                  if (step_sel == STEP_OFFSET || step_sel == STEP_LEAK) begin
                     cal_nxt = 7'h0;
                  end
               end else begin
                  error_nxt = 1'h1;
               end
            end
         end
         ST_PARSE: begin
            if (char_valid) begin
               case (line_r)
                  2'h0: begin
                     if (ch == CH_SEMI) begin
                        line_nxt = 2'h3;
                     end else if (ch == CH_W || ch == CH_C || ch == CH_X) begin
                        row_nxt.cmd = (ch == CH_W) ? CMD_W : ((ch == CH_C) ? CMD_C : CMD_X);
                        row_nxt.cnt = 7'h0;
                        tok_nxt = 7'h0;
                        line_nxt = 2'h1;
                     end else if (ch == CH_EOT) begin
                        if (exit_wait) begin
                           ms_left_nxt = 16'(EXIT_WAIT_MS);
                           tm_nxt = 17'h0;
                           st_nxt = ST_EXIT;
                        end else begin
                           finish = 1'h1;
                        end
                     end else if (!is_ws && ch != CH_NL) begin
                        fault = 1'h1;
                     end
                  end
                  2'h1: begin
                     if (ch == CH_COLON) begin
                        line_nxt = 2'h2;
                     end else begin
                        fault = 1'h1;
                     end
                  end
                  2'h2: begin
                     if (is_hex && (is_dec || row_r.cmd != CMD_X)) begin
                        intok_nxt = 1'h1;
                        if (!intok_r) begin
                           acc_nxt = {12'h0, nib};
                        end else if (row_r.cmd == CMD_X) begin
                           acc_nxt = 16'(acc_r * DEC_BASE + {12'h0, nib});
                        end else begin
                           acc_nxt = {acc_r[11:0], nib};
                        end
                     end else if (is_ws || ch == CH_NL) begin
                        intok_nxt = 1'h0;
                        if (intok_r) begin
                           tok_nxt = 7'(tok_r + 7'h1);
                           if (row_r.cmd == CMD_X) begin
                              row_nxt.ms = acc_r;
                           end else if (tok_r == 7'h0) begin
                              row_nxt.addr7 = acc_r[7:1];
                           end else if (tok_r == 7'h1) begin
                              row_nxt.reg_a = acc_r[7:0];
                           end else if (row_r.cnt == 7'(MAX_BYTES)) begin
                              fault = 1'h1;
                           end else begin
                              mem_we = 1'h1;
                              row_nxt.cnt = 7'(row_r.cnt + 7'h1);
                           end
                        end
                        if (ch == CH_NL && !fault) begin
                           line_nxt = 2'h0;
                           ph_nxt = 2'h0;
                           tm_nxt = 17'h0;
                           seq_nxt = SEQ_AW;
                           if (row_nxt.cmd == CMD_X) begin
                              ms_left_nxt = row_nxt.ms;
                              st_nxt = ST_WAIT;
                           end else if (tok_nxt < 7'h2) begin
                              fault = 1'h1;
                           end else begin
                              st_nxt = (row_nxt.cmd == CMD_C) ? ST_GAP : ST_START;
                           end
                        end
                     end else begin
                        fault = 1'h1;
                     end
                  end
                  default: begin
                     if (ch == CH_NL) begin
                        line_nxt = 2'h0;
                     end else if (ch == CH_EOT) begin
                        finish = 1'h1;
                     end
                  end
               endcase
               if (fault) begin
                  if (ch == CH_EOT) begin
                     decide = 1'h1;
                  end else begin
                     st_nxt = ST_FLUSH;
                  end
               end
            end
         end
         ST_GAP: begin
            if (!slow_poll || gap_r >= 16'(POLL_GAP_MS)) begin
               gap_nxt = 16'h0;
               gsub_nxt = 17'h0;
               st_nxt = ST_START;
            end
         end
         ST_START: begin
            if (tick && ph_r == 2'h3) begin
               st_nxt = ST_BYTE;
               bit_nxt = 4'h0;
               sh_nxt = {row_r.addr7, (seq_r == SEQ_AR)};
            end
         end
         ST_BYTE: begin
            if (tick && ph_r == 2'h2) begin
               if (bit_r < 4'h8 && seq_r == SEQ_DR) begin
                  sh_nxt = {sh_r[6:0], sda_s_r};
               end else if (bit_r == 4'h8 && seq_r != SEQ_DR && sda_s_r) begin
                  fail_nxt = 1'h1;
               end
            end else if (tick && ph_r == 2'h3) begin
               if (bit_r < 4'h8) begin
                  bit_nxt = 4'(bit_r + 4'h1);
                  if (seq_r != SEQ_DR) begin
                     sh_nxt = {sh_r[6:0], 1'h0};
                  end
               end else begin
                  bit_nxt = 4'h0;
                  if (fail_r) begin
                     st_nxt = ST_STOP;
                  end else begin
                     case (seq_r)
                        SEQ_AW: begin
                           seq_nxt = SEQ_REG;
                           sh_nxt = row_r.reg_a;
                        end
                        SEQ_REG: begin
                           if (row_r.cmd == CMD_C) begin
                              seq_nxt = SEQ_AR;
                              st_nxt = ST_START;
                           end else if (row_r.cnt == 7'h0) begin
                              st_nxt = ST_STOP;
                           end else begin
                              seq_nxt = SEQ_DW;
                              bi_nxt = 7'h0;
                              sh_nxt = mem_r[0];
                           end
                        end
                        SEQ_DW: begin
                           if (last) begin
                              st_nxt = ST_STOP;
                           end else begin
                              bi_nxt = 7'(bi_r + 7'h1);
                              sh_nxt = mem_r[7'(bi_r + 7'h1)];
                           end
                        end
                        SEQ_AR: begin
                           bi_nxt = 7'h0;
                           sh_nxt = 8'hff;
                           if (row_r.cnt == 7'h0) begin
                              st_nxt = ST_STOP;
                           end else begin
                              seq_nxt = SEQ_DR;
                           end
                        end
                        default: begin
                           sh_nxt = 8'hff;
                           bi_nxt = 7'(bi_r + 7'h1);
                           if (sh_r != mem_r[bi_r]) begin
                              fail_nxt = 1'h1;
                              st_nxt = ST_STOP;
                           end else if (last) begin
                              st_nxt = ST_STOP;
                           end
                        end
                     endcase
                  end
               end
            end
         end
         ST_STOP: begin
            if (tick && ph_r == 2'h3) begin
               st_nxt = fail_r ? ST_FLUSH : ST_PARSE;
            end
         end
         ST_WAIT, ST_EXIT: begin
            if (ms_left_r == 16'h0) begin
               if (st_r == ST_EXIT) begin
                  finish = 1'h1;
               end else begin
                  st_nxt = ST_PARSE;
               end
            end else if (tm_r == 17'(MS_CYC - 1)) begin
               tm_nxt = 17'h0;
               ms_left_nxt = 16'(ms_left_r - 16'h1);
            end else begin
               tm_nxt = 17'(tm_r + 17'h1);
            end
         end
         ST_FLUSH: begin
            if (char_valid && ch == CH_EOT) begin
               decide = 1'h1;
            end
         end
         default: st_nxt = ST_IDLE;
      endcase
      if (decide) begin
         fail_nxt = 1'h0;
         line_nxt = 2'h0;
         intok_nxt = 1'h0;
         if (retry_r < 4'(MAX_RETRY)) begin
            retry_nxt = 4'(retry_r + 4'h1);
            restart_nxt = 1'h1;
            st_nxt = ST_PARSE;
         end else begin
            error_nxt = 1'h1;
            busy_nxt = 1'h0;
            st_nxt = ST_IDLE;
         end
      end
      if (finish) begin
         busy_nxt = 1'h0;
         done_nxt = 1'h1;
         st_nxt = ST_IDLE;
         if (step_r != STEP_NONE) begin
            cal_nxt[step_r] = 1'h1;
         end
         if (step_r == STEP_LEAK) begin
            cal_nxt[STEP_OFFSET] = 1'h1;
         end
      end
      // open-drain drive: enable low pulls the line low
      scl_low = 1'h0;
      sda_low = 1'h0;
      case (st_r)
         ST_START: begin
            scl_low = (ph_r == 2'h0) || (ph_r == 2'h3);
            sda_low = (ph_r >= 2'h2);
         end
         ST_BYTE: begin
            scl_low = (ph_r == 2'h0) || (ph_r == 2'h3);
            sda_low = (bit_r < 4'h8) ? (seq_r != SEQ_DR && !sh_r[7]) : (seq_r == SEQ_DR && !last);
         end
         ST_STOP: begin
            scl_low = (ph_r == 2'h0);
            sda_low = (ph_r <= 2'h1);
         end
         default: ;
      endcase
      pins_nxt = '{scl_o: 1'h0, scl_oe_n: !scl_low, sda_o: 1'h0, sda_oe_n: !sda_low};
      ready_nxt = (st_nxt == ST_PARSE) || (st_nxt == ST_FLUSH);
   end

   always_ff @(posedge clk) begin
      if (mem_we) begin
         mem_r[mem_wa] <= mem_wd;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         st_r <= ST_IDLE;
         row_r <= '{cmd: CMD_NONE, addr7: 7'h0, reg_a: 8'h0, cnt: 7'h0, ms: 16'h0};
         pins_r <= '{scl_o: 1'h0, scl_oe_n: 1'h1, sda_o: 1'h0, sda_oe_n: 1'h1};
         step_r <= STEP_NONE;
         line_r <= 2'h0;
         ph_r <= 2'h0;
         intok_r <= 1'h0;
         fail_r <= 1'h0;
         ready_r <= 1'h0;
         busy_r <= 1'h0;
         done_r <= 1'h0;
         error_r <= 1'h0;
         restart_r <= 1'h0;
         acc_r <= 16'h0;
         ms_left_r <= 16'h0;
         gap_r <= 16'hffff;
         tok_r <= 7'h0;
         bi_r <= 7'h0;
         cal_r <= 7'h0;
         tm_r <= 17'h0;
         gsub_r <= 17'h0;
         bit_r <= 4'h0;
         retry_r <= 4'h0;
         sh_r <= 8'hff;
         seq_r <= SEQ_AW;
      end else begin
         st_r <= st_nxt;
         row_r <= row_nxt;
         pins_r <= pins_nxt;
         step_r <= step_nxt;
         line_r <= line_nxt;
         ph_r <= ph_nxt;
         intok_r <= intok_nxt;
         fail_r <= fail_nxt;
         ready_r <= ready_nxt;
         busy_r <= busy_nxt;
         done_r <= done_nxt;
         error_r <= error_nxt;
         restart_r <= restart_nxt;
         acc_r <= acc_nxt;
         ms_left_r <= ms_left_nxt;
         gap_r <= gap_nxt;
         tok_r <= tok_nxt;
         bi_r <= bi_nxt;
         cal_r <= cal_nxt;
         tm_r <= tm_nxt;
         gsub_r <= gsub_nxt;
         bit_r <= bit_nxt;
         retry_r <= retry_nxt;
         sh_r <= sh_nxt;
         seq_r <= seq_nxt;
      end
   end

   assign char_ready = ready_r;
   assign busy = busy_r;
   assign done = done_r;
   assign error = error_r;
   assign restart = restart_r;
   assign retry_cnt = retry_r;
   assign cal_done = cal_r;
   assign scl_o = pins_r.scl_o;
   assign scl_oe_n = pins_r.scl_oe_n;
   assign sda_o = pins_r.sda_o;
   assign sda_oe_n = pins_r.sda_oe_n;
endmodule

// file: fcfs_gauge_model.sv
// behavioural gauge: two-wire target with auto-incrementing byte registers
// the bench resolves both lines as wired-and with pull-ups
`timescale 1ns/1ps
module fcfs_gauge_model #(
   parameter logic [6:0] ADDR = 7'h55
) (
   input wire logic scl,
   input wire logic sda,
   input wire logic slow,
   output logic scl_low,
   output logic sda_low
);
   logic [7:0] mem [256];
   logic [7:0] sh, tx, ptr;
   logic on = 1'b0, txon = 1'b0, first, hit, rd, regp, ab, mack;
   int k;
   initial {scl_low, sda_low} = 2'b00;
   always @(negedge sda) if (scl) begin
      on = 1'b1;
      first = 1'b1;
      k = 0;
   end
   always @(posedge sda) if (scl) begin
      on = 1'b0;
      txon = 1'b0;
   end
   always @(posedge scl) if (on) begin
      k++;
      if (k <= 8) sh = {sh[6:0], sda};
      mack = !sda;
   end
   // acknowledge, store or shift out after each falling clock
   always @(negedge scl) if (on) begin
      sda_low = 1'b0;
      if (k == 8) begin
         ab = first;
         if (first) {hit, rd, regp} = {sh[7:1] == ADDR, sh[0], !sh[0]};
         else if (hit && !rd) begin
            if (regp) ptr = sh;
            else mem[ptr] = sh;
            if (!regp) ptr++;
            regp = 1'b0;
         end
         first = 1'b0;
         sda_low = hit && (ab || !rd);
      end else if (k == 9) begin
         k = 0;
         txon = hit && rd && (ab || mack);
         if (txon) tx = mem[ptr++];
      end
      if (txon && k < 8) sda_low = !tx[7 - k];
      if (slow) begin
         scl_low = 1'b1;
         #7700 scl_low = 1'b0;
      end
   end
endmodule

// file: fcfs_chk.sv
// port assertions for the stream host
// bound into every fcfs_stream_host; one clock domain
`timescale 1ns/1ps
module fcfs_chk #(
   parameter int MS_CYC = fcfs_pkg::MS_CYC_DEF
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic start,
   input wire fcfs_pkg::fcfs_step_type step_sel,
   input wire logic gauge_open,
   input wire logic busy,
   input wire logic error,
   input wire logic restart,
   input wire logic [3:0] retry_cnt,
   input wire logic [6:0] cal_done
);
   import fcfs_pkg::*;
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   sequence s_take;
      start && !busy;
   endsequence
   sequence s_open;
      s_take ##0 gauge_open;
   endsequence
   chk_shut_refuse: assert property (s_take ##0 !gauge_open |=> error && !busy)
      else $error("closed start ran");
   chk_curr_order: assert property (s_open ##0 step_sel == STEP_CURR && !cal_done[1] |=> error)
      else $error("early current step");
   chk_volt_order: assert property (s_open ##0 step_sel == STEP_VOLT && !cal_done[3] |=> error)
      else $error("early voltage step");
   chk_store_order: assert property (s_open ##0 step_sel == STEP_STORE && !cal_done[5] |=> !busy)
      else $error("early store step");
   chk_leak_offset: assert property ($rose(cal_done[2]) |-> cal_done[1])
      else $error("leak without offset");
   chk_restart_pulse: assert property (restart |=> !restart && busy ##1 busy)
      else $error("bad restart");
   chk_error_idle: assert property (error |-> !busy)
      else $error("error while busy");
   chk_retry_bound: assert property (int'(retry_cnt) <= MAX_RETRY)
      else $error("too many retries");
endmodule
bind fcfs_stream_host fcfs_chk #(.MS_CYC(MS_CYC)) u_chk (.clk(clk), .rst_n(rst_n), .start(start),
   .step_sel(step_sel), .gauge_open(gauge_open), .busy(busy), .error(error), .restart(restart),
   .retry_cnt(retry_cnt), .cal_done(cal_done));

// file: testbench.sv
// self-checking bench: stream host driving a behavioural gauge
// inputs change on the falling clock edge; lines are wired-and with pull-ups
`timescale 1ns/1ps
module testbench;
   import fcfs_pkg::*;
   localparam int MS = 20;
   logic clk = 1'b0, rst_n = 1'b0, char_valid = 1'b0, start = 1'b0, gauge_open = 1'b0, slow = 1'b0;
   logic exit_wait = 1'b0;
   logic char_ready, busy, done, error, restart, scl_oe_n, sda_oe_n, m_scl_low, m_sda_low, scl_o, sda_o;
   logic [7:0] char_data = 8'h00;
   logic [3:0] retry_cnt;
   logic [6:0] cal_done;
   fcfs_step_type step_sel = STEP_NONE;
   wire scl = scl_oe_n & !m_scl_low;
   wire sda = sda_oe_n & !m_sda_low;
   int fails = 0, cmp_count = 0, cyc = 0;
   time t0;
   always #5 clk = ~clk;
   fcfs_stream_host #(.MS_CYC(MS)) dut (.clk(clk), .rst_n(rst_n), .char_data(char_data), .char_valid(char_valid),
      .char_ready(char_ready), .start(start), .step_sel(step_sel), .gauge_open(gauge_open), .slow_poll(slow),
      .exit_wait(exit_wait), .busy(busy), .done(done), .error(error), .restart(restart), .retry_cnt(retry_cnt),
      .cal_done(cal_done), .scl_i(scl), .scl_o(scl_o), .scl_oe_n(scl_oe_n), .sda_i(sda), .sda_o(sda_o),
      .sda_oe_n(sda_oe_n));
   fcfs_gauge_model gm (.scl(scl), .sda(sda), .slow(slow), .scl_low(m_scl_low), .sda_low(m_sda_low));
   always @(posedge clk) if (++cyc == 105000) begin
      fails++;
      tally_and_finish();
   end
   task automatic check(logic [31:0] got, logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         fails++;
         $display("[ERR] %0t got %h want %h", $time, got, exp);
      end
   endtask
   task automatic tally_and_finish();
      $display("compares %0d mismatches %0d", cmp_count, fails);
      if (fails == 0 && cmp_count > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   // each char is held until the host takes it
   task automatic send(string s);
      for (int i = 0; i < s.len(); i++) begin
         @(negedge clk);
         char_data = s[i];
         char_valid = 1'b1;
         while (char_ready !== 1'b1) @(negedge clk);
      end
      @(negedge clk);
      char_valid = 1'b0;
   endtask
   // start a step; on each restart the retry text is sent from its first char
   task automatic run(fcfs_step_type st, string s1, string s2);
      @(negedge clk);
      step_sel = st;
      start = 1'b1;
      t0 = $time;
      @(negedge clk);
      start = 1'b0;
      if (busy !== 1'b1) return;
      send(s1);
      forever begin
         if (restart === 1'b1) send(s2);
         else if (busy !== 1'b1) break;
         else @(negedge clk);
      end
   endtask
   task automatic refuse_steps();
      run(STEP_OFFSET, "", "");
      check({busy, error}, 2'b01);
      gauge_open = 1'b1;
      run(STEP_CURR, "", "");
      check({busy, error}, 2'b01);
      run(STEP_VOLT, "", "");
      check({busy, error}, 2'b01);
   endtask
   task automatic leak_stream();
      slow = 1'b1;
      run(STEP_LEAK, ";note\n\nW: AA 55 AB CD\nC: AA 56 CD\n\004", "\004");
      slow = 1'b0;
      check({done, retry_cnt}, 5'h10);
      check(cal_done, 7'h06);
      check({gm.mem[8'h55], gm.mem[8'h56]}, 16'habcd);
      check({scl_o, sda_o}, 2'b00);
   endtask
   task automatic delay_row();
      exit_wait = 1'b1;
      run(STEP_CURR, "X: 3\n\004", "\004");
      exit_wait = 1'b0;
      check($time - t0 >= 3 * MS * 10, 1'b1);
      check($time - t0 >= (3 + EXIT_WAIT_MS) * MS * 10, 1'b1);
      check(cal_done, 7'h0e);
      run(STEP_STORE, "", "");
      check({busy, error}, 2'b01);
   endtask
   task automatic retry_paths();
      run(STEP_OFFSET, "W: 20 00\n\004", "X: 1\n\004");
      check({done, retry_cnt, cal_done}, 12'h882);
      run(STEP_OFFSET, "X: 1G\n\004", "X: 1G\n\004");
      check({error, busy, retry_cnt}, 6'h23);
   endtask
   initial begin
      repeat (16) @(negedge clk);
      rst_n = 1'b1;
      refuse_steps();
      leak_stream();
      delay_row();
      retry_paths();
      tally_and_finish();
   end
endmodule
